// ===== rtl/dolb_ctl_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dolb_ctl_filter
  import dolb_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control samples
  input  wire logic       word_stb,
  input  wire logic       filt_en,
  input  wire logic [2:0] raw,
  output logic      [2:0] filt
);

  typedef struct packed {
    logic [2:0] h0;
    logic [2:0] h1;
    logic [2:0] out;
  } dolb_filt_st_t;

  dolb_filt_st_t st;
  dolb_filt_st_t nx;

  // A level must be seen on three words in a row before it passes.
  always_comb begin
    nx = st;
    if (word_stb) begin
      nx.h0 = raw;
      nx.h1 = st.h0;
      for (int i = 0; i < 3; i++) begin
        if (!filt_en || (raw[i] == st.h0[i] && st.h0[i] == st.h1[i])) begin
          nx.out[i] = raw[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign filt = st.out;

  filter_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(filt_en) |-> ((st.out ^ $past(st.out)) &
                        ($past(raw ^ st.h0) | $past(st.h0 ^ st.h1))) == 3'h0)
    else $error("control filter passed a short pulse");

endmodule
`default_nettype wire

// ===== rtl/dolb_pkg.sv
// What this block does
// - Hold forces outputs low except lock and pass
// - Host toggle releases hold only while locked
// - Lock falling edge re-arms enabled hold
// - Manual re-arm honoured only while locked
// - Outputs float until power-down released
// - Hold strap high disables output state select
// - Edge select picks launch edge
// - Filter drops one or two clock pulses
// - Config from straps or registers
// - Straps sampled at power-up, default low
// - Check payloads against PRBS7 sequence
// - Errored payload pulses pass low half-period
// - Test end holds pass result
// - Test pattern gives checkerboard outputs
// - Bad embedded clock bits drop lock
// - Lost stream drops lock, outputs per select
package dolb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DOLB_CFG_OFS    = 8'h00;
  localparam logic [7:0] DOLB_STATUS_OFS = 8'h04;
  localparam logic [7:0] DOLB_ERRCNT_OFS = 8'h08;

  localparam int CFG_REG_SEL  = 0;
  localparam int CFG_EDGE     = 1;
  localparam int CFG_FILT     = 2;
  localparam int CFG_OSS      = 3;
  localparam int CFG_HOLD_EN  = 4;
  localparam int CFG_HOLD_SET = 5;
  localparam logic [7:0] CFG_RESET = 8'h30;

  localparam int ST_LOCK  = 0;
  localparam int ST_PASS  = 1;
  localparam int ST_HOLD  = 2;
  localparam int ST_TEST  = 3;
  localparam int ST_CHECK = 4;
  localparam int ST_ERR   = 5;

  // ---------------------------------------------------------------
  // Synchroniser vector layout
  // ---------------------------------------------------------------
  localparam int SY_PAY   = 0;
  localparam int SY_VS    = 24;
  localparam int SY_DE    = 26;
  localparam int SY_CB    = 27;
  localparam int SY_ACT   = 29;
  localparam int SY_TCODE = 30;
  localparam int SY_PD    = 31;
  localparam int SY_STE   = 32;
  localparam int SY_SEDGE = 33;
  localparam int SY_SOSS  = 34;
  localparam int SY_SFILT = 35;
  localparam int SY_SHOLD = 36;
  localparam int SY_LCLK  = 37;
  localparam int SY_W     = 38;

  // ---------------------------------------------------------------
  // Link timing and patterns
  // ---------------------------------------------------------------
  localparam logic [1:0]  CLK_BITS_GOOD   = 2'h2;
  localparam logic [2:0]  LOCK_GOOD_WORDS = 3'h4;
  localparam logic [23:0] CHECKER_A       = 24'haaaaaa;
  localparam logic [23:0] CHECKER_B       = 24'h555555;
  localparam logic [15:0] ERRCNT_MAX      = 16'hffff;

  typedef enum logic [2:0] {OM_OFF, OM_LOW, OM_FLOAT, OM_TEST, OM_LIVE} dolb_omode_t;

  // Expected PRBS7 payload (x^7 + x^6 + 1) that follows a given generator state.
  function automatic logic [23:0] dolb_prbs_word(input logic [6:0] seed);
    logic [6:0]  s;
    logic [23:0] w;
    s = seed;
    w = 24'h000000;
    for (int i = 0; i < 24; i++) begin
      w[i] = s[6] ^ s[5];
      s    = {s[5:0], s[6] ^ s[5]};
    end
    return w;
  endfunction

endpackage

// ===== rtl/dolb_prbs_check.sv
`timescale 1ns/1ps
`default_nettype none
module dolb_prbs_check
  import dolb_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Payload stream
  input  wire logic        word_stb,
  input  wire logic        check_en,
  input  wire logic [23:0] payload,
  output logic             err_stb
);

  typedef struct packed {
    logic        have_prev;
    logic [6:0]  seed;
    logic        err;
  } dolb_prbs_st_t;

  dolb_prbs_st_t st;
  dolb_prbs_st_t nx;
  logic [23:0]   expect_w;

  // The generator state is rebuilt from the last seven bits of each word, so
  // the checker locks without a preamble; the first word only seeds it.
  always_comb begin
    nx       = st;
    nx.err   = 1'b0;
    expect_w = dolb_prbs_word(st.seed);
    if (!check_en) begin
      nx.have_prev = 1'b0;
    end else if (word_stb) begin
      nx.have_prev = 1'b1;
      nx.seed      = {payload[17], payload[18], payload[19], payload[20],
                      payload[21], payload[22], payload[23]};
      nx.err       = st.have_prev && (payload != expect_w);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign err_stb = st.err;

  prbs_mismatch_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_stb && check_en && st.have_prev && payload != expect_w |=> err_stb)
    else $error("payload mismatch not flagged");

endmodule
`default_nettype wire

// ===== rtl/dolb_top.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dolb_top
  import dolb_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Recovered link word and status
  input  wire logic        link_pixel_clk,
  input  wire logic [23:0] link_payload,
  input  wire logic        link_vs,
  input  wire logic        link_hs,
  input  wire logic        link_de,
  input  wire logic [1:0]  link_clk_bits,
  input  wire logic        link_stream_active,
  input  wire logic        link_test_code_seen,
  // Control pins and straps
  input  wire logic        power_down_n,
  input  wire logic        self_test_enable,
  input  wire logic        strap_edge_select,
  input  wire logic        strap_oss,
  input  wire logic        strap_filter_en,
  input  wire logic        pass_pin_in,
  // Parallel outputs
  output logic      [23:0] color_data,
  output logic             color_oe,
  output logic             vertical_sync,
  output logic             horizontal_sync,
  output logic             data_valid_enable,
  output logic             sync_oe,
  output logic             pixel_clk_out,
  output logic             pixel_clk_oe,
  output logic             lock_out,
  output logic             lock_oe,
  output logic             pass_out,
  output logic             pass_oe
);

  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic            lclk_d;
    logic            pd_d;
    logic            straps_ok;
    logic            strap_hold;
    logic            strap_edge;
    logic            strap_oss;
    logic            strap_filt;
    logic [7:0]      cfg;
    logic [2:0]      good_cnt;
    logic            lock;
    logic            hold;
    logic            chk;
    logic            tested;
    logic            any_err;
    logic            pass_low;
    logic [15:0]     err_cnt;
    logic            phase;
    logic [23:0]     color;
    logic            vs;
    logic            hs;
    logic            de;
    logic            color_oe;
    logic            pclk_o;
    logic            pass_o;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } dolb_top_st_t;

  dolb_top_st_t    st;
  dolb_top_st_t    nx;
  logic [SY_W-1:0] sync_in;
  logic            pd_s;
  logic            samp;
  logic            wstb;
  logic            wfall;
  logic            launch;
  logic            regsel;
  logic            edge_eff;
  logic            filt_eff;
  logic            oss_eff;
  logic            hold_en;
  logic            test_seen;
  logic            acc_first;
  logic            wr_cfg;
  logic [2:0]      filt;
  logic            err_stb;
  dolb_omode_t     omode;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  assign sync_in = {link_pixel_clk, pass_pin_in, strap_filter_en, strap_oss,
                    strap_edge_select, self_test_enable, power_down_n,
                    link_test_code_seen, link_stream_active, link_clk_bits,
                    link_de, link_hs, link_vs, link_payload};

  dolb_ctl_filter u_filter (
    .pclk     (pclk),
    .presetn  (presetn),
    .word_stb (wstb),
    .filt_en  (filt_eff),
    .raw      (st.s2[SY_DE:SY_VS]),
    .filt     (filt)
  );

  dolb_prbs_check u_prbs (
    .pclk     (pclk),
    .presetn  (presetn),
    .word_stb (wstb),
    .check_en (st.chk),
    .payload  (st.s2[SY_PAY+23:SY_PAY]),
    .err_stb  (err_stb)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nx        = st;
    nx.s1     = sync_in;
    nx.s2     = st.s1;
    nx.lclk_d = st.s2[SY_LCLK];
    pd_s      = st.s2[SY_PD];
    nx.pd_d   = pd_s;
    samp      = pd_s && !st.pd_d;
    // The link clock is only sampled, so its edges are seen up to three cycles late.
    wstb      = st.s2[SY_LCLK] && !st.lclk_d;
    wfall     = !st.s2[SY_LCLK] && st.lclk_d;

    regsel    = st.cfg[CFG_REG_SEL];
    edge_eff  = regsel ? st.cfg[CFG_EDGE]    : st.strap_edge;
    filt_eff  = regsel ? st.cfg[CFG_FILT]    : st.strap_filt;
    hold_en   = regsel ? st.cfg[CFG_HOLD_EN] : st.strap_hold;
    oss_eff   = !st.strap_hold && (regsel ? st.cfg[CFG_OSS] : st.strap_oss);
    launch    = edge_eff ? wstb : wfall;
    test_seen = st.s2[SY_TCODE] && st.lock;

    acc_first = psel && penable && !st.pready;
    wr_cfg    = psel && penable && st.pready && pwrite && paddr == DOLB_CFG_OFS && pd_s;

    // APB: one wait state, read data built in the first access cycle.
    nx.pready  = acc_first;
    nx.pslverr = 1'b0;
    nx.prdata  = 32'h00000000;
    if (acc_first) begin
      if (paddr == DOLB_CFG_OFS) begin
        nx.prdata = {24'h000000, st.cfg};
      end else if (paddr == DOLB_STATUS_OFS) begin
        nx.prdata[ST_LOCK]  = st.lock;
        nx.prdata[ST_PASS]  = st.pass_o;
        nx.prdata[ST_HOLD]  = st.hold;
        nx.prdata[ST_TEST]  = test_seen;
        nx.prdata[ST_CHECK] = st.chk;
        nx.prdata[ST_ERR]   = st.any_err;
      end else if (paddr == DOLB_ERRCNT_OFS) begin
        nx.prdata = {16'h0000, st.err_cnt};
      end else begin
        nx.pslverr = 1'b1;
      end
    end
    if (wr_cfg) begin
      nx.cfg = pwdata[7:0];
    end

    // Lock tracking on each recovered word.
    if (!pd_s || !st.s2[SY_ACT]) begin
      nx.lock     = 1'b0;
      nx.good_cnt = 3'h0;
    end else if (wstb) begin
      if (st.s2[SY_CB+1:SY_CB] == CLK_BITS_GOOD) begin
        if (st.good_cnt == LOCK_GOOD_WORDS) begin
          nx.lock = 1'b1;
        end else begin
          nx.good_cnt = st.good_cnt + 3'h1;
        end
      end else begin
        nx.lock     = 1'b0;
        nx.good_cnt = 3'h0;
      end
    end

    // Strap capture and outputs-low hold.
    if (samp) begin
      nx.straps_ok  = 1'b1;
      nx.strap_hold = st.s2[SY_SHOLD];
      nx.strap_edge = st.s2[SY_SEDGE];
      nx.strap_oss  = st.s2[SY_SOSS];
      nx.strap_filt = st.s2[SY_SFILT];
      nx.hold       = st.s2[SY_SHOLD];
    end else if (st.straps_ok) begin
      if (st.lock && !nx.lock && hold_en) begin
        nx.hold = 1'b1;
      end else if (wr_cfg && st.lock) begin
        if (!st.cfg[CFG_HOLD_SET] && pwdata[CFG_HOLD_SET] && hold_en) begin
          nx.hold = 1'b1;
        end else if (st.cfg[CFG_HOLD_SET] && !pwdata[CFG_HOLD_SET]) begin
          nx.hold = 1'b0;
        end
      end
    end

    // Self-test checking, enable already through the synchroniser.
    nx.chk = pd_s && st.s2[SY_STE];
    if (nx.chk && !st.chk) begin
      nx.tested  = 1'b1;
      nx.any_err = 1'b0;
      nx.err_cnt = 16'h0000;
    end
    if (wfall) begin
      nx.pass_low = 1'b0;
    end
    if (st.chk && err_stb) begin
      nx.any_err  = 1'b1;
      nx.pass_low = 1'b1;
      if (st.err_cnt != ERRCNT_MAX) begin
        nx.err_cnt = st.err_cnt + 16'h0001;
      end
    end

    // Power-down returns configuration to CFG_RESET and clears results; straps are taken again on release.
    if (!pd_s) begin
      nx.cfg       = CFG_RESET;
      nx.straps_ok = 1'b0;
      nx.hold      = 1'b0;
      nx.tested    = 1'b0;
      nx.any_err   = 1'b0;
      nx.pass_low  = 1'b0;
      nx.err_cnt   = 16'h0000;
    end

    // Output state.
    if (!st.straps_ok) begin
      omode = OM_OFF;
    end else if (st.hold) begin
      omode = OM_LOW;
    end else if (!st.lock) begin
      omode = oss_eff ? OM_FLOAT : OM_LOW;
    end else if (test_seen) begin
      omode = OM_TEST;
    end else begin
      omode = OM_LIVE;
    end

    // On the capture cycle the straps are read from the synchroniser, so an output
    // that must float is never driven low for one cycle before it lets go.
    nx.color_oe = nx.straps_ok && (samp ? (st.s2[SY_SHOLD] || !st.s2[SY_SOSS])
                                        : omode != OM_FLOAT);
    case (omode)
      OM_LIVE: begin
        nx.pclk_o = st.s2[SY_LCLK];
        if (launch) begin
          nx.color = st.s2[SY_PAY+23:SY_PAY];
          nx.vs    = filt[0];
          nx.hs    = filt[1];
          nx.de    = filt[2];
        end
      end
      OM_TEST: begin
        nx.pclk_o = st.s2[SY_LCLK];
        nx.vs     = 1'b0;
        nx.hs     = 1'b0;
        nx.de     = 1'b0;
        if (launch) begin
          nx.phase = !st.phase;
          nx.color = st.phase ? CHECKER_A : CHECKER_B;
        end
      end
      default: begin
        nx.pclk_o = 1'b0;
        nx.color  = 24'h000000;
        nx.vs     = 1'b0;
        nx.hs     = 1'b0;
        nx.de     = 1'b0;
      end
    endcase

    // Pass shows lock until a test starts, error pulses while it runs, then the held result.
    if (!nx.straps_ok) begin
      nx.pass_o = 1'b0;
    end else if (st.chk) begin
      nx.pass_o = !st.pass_low;
    end else if (st.tested) begin
      nx.pass_o = !st.any_err;
    end else begin
      nx.pass_o = st.lock;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st     <= '0;
      st.cfg <= CFG_RESET;
    end else begin
      st <= nx;
    end
  end

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign color_data        = st.color;
  assign color_oe          = st.color_oe;
  assign vertical_sync     = st.vs;
  assign horizontal_sync   = st.hs;
  assign data_valid_enable = st.de;
  assign sync_oe           = st.color_oe;
  assign pixel_clk_out     = st.pclk_o;
  assign pixel_clk_oe      = st.color_oe;
  assign lock_out          = st.lock;
  assign lock_oe           = st.straps_ok;
  assign pass_out          = st.pass_o;
  assign pass_oe           = st.straps_ok;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  hold_forces_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.hold |=> st.color == 24'h000000 && !st.pclk_o && !st.vs && !st.hs && !st.de)
    else $error("outputs not low during hold");

  release_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.hold) |-> $past(st.lock) || !$past(pd_s))
    else $error("hold released without lock");

  lock_fall_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.lock) && $past(hold_en) && $past(pd_s) && $past(st.straps_ok) |-> st.hold)
    else $error("hold not re-armed on lock loss");

  manual_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.hold) |-> $past(st.lock) || $past(samp))
    else $error("hold set without lock");

  float_before_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st.straps_ok |-> !color_oe && !pixel_clk_oe && !sync_oe && !pass_oe)
    else $error("outputs driven before strap capture");

  oss_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.straps_ok && st.strap_hold |-> st.color_oe)
    else $error("outputs floated with hold strap high");

  launch_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st.color) && $past(omode == OM_LIVE) |-> $past(launch))
    else $error("data launched off the selected edge");

  pass_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_stb && st.chk ##1 st.chk |=> !st.pass_o)
    else $error("errored payload did not pulse pass low");

  result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.tested && !st.chk && st.straps_ok && pd_s |=> st.pass_o == !$past(st.any_err))
    else $error("pass result not held after test");

  lock_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    wstb && st.s2[SY_CB+1:SY_CB] != CLK_BITS_GOOD |=> !st.lock)
    else $error("lock kept with bad clock bits");

endmodule
`default_nettype wire

// ===== verification/dolb_ser_model.sv
`timescale 1ns/1ps
`default_nettype none
module dolb_ser_model
  import dolb_pkg::*;
(
  // Controls from the bench
  input  wire logic        run,
  input  wire logic        prbs,
  input  wire logic        bad,
  input  wire logic        inj,
  input  wire logic [23:0] word,
  input  wire logic [2:0]  ctl,
  // Recovered link side
  output logic             lclk,
  output logic      [23:0] pay,
  output logic             vs,
  output logic             hs,
  output logic             de,
  output logic      [1:0]  cbits,
  output logic             active,
  output logic             tcode,
  output int               n_bad
);
  // ---------------------------------------------------------------
  // Link clock and word launch
  // ---------------------------------------------------------------
  logic [6:0]  s;
  logic [23:0] w;
  int          k;

  // The clock parks low when the stream stops, as a dead link would.
  initial begin
    lclk = 1'b0;
    #7;
    forever #200 if (run || lclk) lclk = ~lclk;
  end

  initial begin
    s     = 7'h7f;
    k     = 0;
    n_bad = 0;
    pay   = 24'h000000;
    {vs, hs, de} = 3'h0;
    cbits = CLK_BITS_GOOD;
  end

  assign active = run;
  assign tcode  = prbs;

  // Fields change on the falling edge so they are settled around the rising edge.
  always @(negedge lclk) begin
    k = k + 1;
    w = word;
    if (prbs) begin
      for (int i = 0; i < 24; i++) begin
        w[i] = s[6] ^ s[5];
        s    = {s[5:0], s[6] ^ s[5]};
      end
      // Only bit 0 is flipped, so the seed of the next word stays intact.
      if (inj && k % 8 == 0) begin
        w[0]  = ~w[0];
        n_bad = n_bad + 1;
      end
    end
    pay          <= w;
    {vs, hs, de} <= ctl;
    cbits        <= bad ? 2'h0 : CLK_BITS_GOOD;
  end

  // A stopped link must not keep showing its last word.
  always @(negedge run) pay <= ~pay;
endmodule
`default_nettype wire

// ===== verification/dolb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dolb_top_tb
  import dolb_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } dolb_exp_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] link_payload, color_data, word, prev_col;
  logic [1:0]  link_clk_bits;
  logic [2:0]  ctl, base;
  logic        link_pixel_clk, link_vs, link_hs, link_de, link_stream_active;
  logic        link_test_code_seen, power_down_n, self_test_enable, strap_edge_select;
  logic        strap_oss, strap_filter_en, pass_pin_in, color_oe, vertical_sync;
  logic        horizontal_sync, data_valid_enable, sync_oe, pixel_clk_out, pixel_clk_oe;
  logic        lock_out, lock_oe, pass_out, pass_oe, prev_pass, run, prbs, bad, inj;
  logic        watch, glitch, cnt_on, edge_chk, exp_edge;
  int          n_bad, miscompares, n_checks, cyc, npulse;
  dolb_exp_t   q[$];
  dolb_exp_t   e;

  dolb_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_pixel_clk, .link_payload, .link_vs, .link_hs, .link_de, .link_clk_bits,
    .link_stream_active, .link_test_code_seen, .power_down_n, .self_test_enable,
    .strap_edge_select, .strap_oss, .strap_filter_en, .pass_pin_in, .color_data, .color_oe,
    .vertical_sync, .horizontal_sync, .data_valid_enable, .sync_oe, .pixel_clk_out,
    .pixel_clk_oe, .lock_out, .lock_oe, .pass_out, .pass_oe
  );

  dolb_ser_model ser (
    .run, .prbs, .bad, .inj, .word, .ctl, .n_bad, .lclk(link_pixel_clk), .pay(link_payload),
    .vs(link_vs), .hs(link_hs), .de(link_de), .cbits(link_clk_bits),
    .active(link_stream_active), .tcode(link_test_code_seen)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    q.push_back('{rd: !wr && !err, err: err, data: exp});
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wl(input logic v);
    repeat (400) if (lock_out !== v) @(posedge pclk);
    chk("lock_out", lock_out, v);
  endtask

  task automatic feed(input int n);
    repeat (n) begin
      @(negedge link_pixel_clk);
      @(posedge pclk) word <= 24'($urandom);
    end
  endtask

  // The pulse is aligned to launch edges so it lasts exactly n words.
  task automatic pulse(input logic [2:0] v, input int n);
    @(negedge link_pixel_clk);
    @(posedge pclk) ctl <= v;
    repeat (n) @(negedge link_pixel_clk);
    @(posedge pclk) ctl <= base;
    cy(48);
  endtask

  // ---------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", pslverr, e.err);
      if (e.rd) chk("prdata", prdata, e.data);
    end
    if (edge_chk && color_data !== prev_col) chk("launch edge", pixel_clk_out, exp_edge);
    if (watch && {vertical_sync, horizontal_sync, data_valid_enable} !== base) glitch <= 1'b1;
    if (cnt_on && prev_pass === 1'b1 && pass_out === 1'b0) npulse <= npulse + 1;
    prev_col  <= color_data;
    prev_pass <= pass_out;
    cyc       <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn, power_down_n, self_test_enable} = 6'h00;
    {strap_edge_select, strap_oss, strap_filter_en, pass_pin_in} = 4'he;
    {run, prbs, bad, inj, watch, glitch, cnt_on, edge_chk, exp_edge} = 9'h000;
    {prev_pass, prev_col, base, ctl, paddr, pwdata, word} = '0;
    void'($urandom(32'h92cefa43));
    cy(2);
    presetn <= 1'b1;
    cy(4);
    chk("color_oe", color_oe, 1'b0);
    chk("pixel_clk_oe", pixel_clk_oe, 1'b0);
    chk("sync_oe", sync_oe, 1'b0);
    chk("pass_oe", pass_oe, 1'b0);
    apb(1'b0, DOLB_CFG_OFS, 32'h0, {24'h0, CFG_RESET}, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    power_down_n <= 1'b1;
    run          <= 1'b1;
    word         <= 24'($urandom);
    cy(8);
    chk("lock_oe", lock_oe, 1'b1);
    chk("pass_oe", pass_oe, 1'b1);
    chk("float unlocked", color_oe, 1'b0);
    wl(1'b1);
    exp_edge <= 1'b1;
    edge_chk <= 1'b1;
    feed(12);
    edge_chk <= 1'b0;
    cy(40);
    chk("live data", color_data, word);
    watch <= 1'b1;
    pulse(3'h7, 2);
    pulse(3'h7, 1);
    watch <= 1'b0;
    chk("glitch high", glitch, 1'b0);
    ctl <= 3'h7;
    cy(48);
    chk("ctl step", {vertical_sync, horizontal_sync, data_valid_enable}, 3'h7);
    base <= 3'h7;
    watch <= 1'b1;
    pulse(3'h0, 2);
    watch <= 1'b0;
    chk("glitch low", glitch, 1'b0);
    run <= 1'b0;
    wl(1'b0);
    cy(8);
    chk("float lost", color_oe, 1'b0);
    // A second power-up with the hold strap high.
    power_down_n <= 1'b0;
    pass_pin_in  <= 1'b1;
    run          <= 1'b1;
    cy(6);
    chk("pd float", color_oe, 1'b0);
    power_down_n <= 1'b1;
    cy(8);
    chk("oss off", color_oe, 1'b1);
    chk("sync_oe held", sync_oe, 1'b1);
    wl(1'b1);
    cy(16);
    chk("held", color_data, 24'h0);
    chk("lock kept", lock_out, 1'b1);
    apb(1'b1, DOLB_CFG_OFS, 32'h11, 32'h0, 1'b0);
    exp_edge <= 1'b0;
    edge_chk <= 1'b1;
    feed(12);
    edge_chk <= 1'b0;
    cy(40);
    chk("released", color_data, word);
    apb(1'b0, DOLB_STATUS_OFS, 32'h0, 32'h03, 1'b0);
    apb(1'b1, DOLB_CFG_OFS, 32'h31, 32'h0, 1'b0);
    cy(8);
    chk("rearmed", color_data, 24'h0);
    apb(1'b1, DOLB_CFG_OFS, 32'h11, 32'h0, 1'b0);
    bad <= 1'b1;
    wl(1'b0);
    apb(1'b1, DOLB_CFG_OFS, 32'h31, 32'h0, 1'b0);
    apb(1'b1, DOLB_CFG_OFS, 32'h11, 32'h0, 1'b0);
    bad <= 1'b0;
    wl(1'b1);
    cy(40);
    chk("lock rearm", color_data, 24'h0);
    apb(1'b1, DOLB_CFG_OFS, 32'h31, 32'h0, 1'b0);
    apb(1'b1, DOLB_CFG_OFS, 32'h11, 32'h0, 1'b0);
    cy(40);
    chk("live again", color_data, word);
    prbs <= 1'b1;
    cy(80);
    chk("checker", color_data === CHECKER_A || color_data === CHECKER_B, 1'b1);
    chk("test syncs", {vertical_sync, horizontal_sync, data_valid_enable}, 3'h0);
    self_test_enable <= 1'b1;
    cy(40);
    cnt_on <= 1'b1;
    inj    <= 1'b1;
    cy(320);
    inj <= 1'b0;
    cy(80);
    cnt_on <= 1'b0;
    chk("pass pulses", npulse, n_bad);
    self_test_enable <= 1'b0;
    cy(40);
    chk("fail held", pass_out, 1'b0);
    apb(1'b0, DOLB_ERRCNT_OFS, 32'h0, n_bad, 1'b0);
    self_test_enable <= 1'b1;
    cy(160);
    self_test_enable <= 1'b0;
    cy(40);
    chk("pass held", pass_out, 1'b1);
    prbs <= 1'b0;
    cy(8);
    wrap_up();
  end
endmodule
`default_nettype wire
